// *** hw/swr_pkg.sv ***
package swr_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] DEVICE_CONTROL_REG_OFS = 4'h0;
    localparam logic [3:0] DEV_CFG_OFS = 4'h1;
    localparam logic [3:0] AUTO_MON_OFS = 4'h2;
    localparam logic [3:0] STATUS_OFS = 4'h3;
    localparam logic [3:0] SYS_FAULT_OFS = 4'h4;
    localparam logic [3:0] UV_FAULT_OFS = 4'h5;
    localparam logic [3:0] OV_FAULT_OFS = 4'h6;
    localparam logic [3:0] AUX_FAULT_OFS = 4'h7;
    localparam logic [3:0] DEV_FAULT_OFS = 4'h8;
    localparam logic [3:0] ADDR_OFS = 4'h9;
    localparam logic [3:0] SAMPLE_CMD_OFS = 4'hA;
    // device control bits
    localparam int PWR_DOWN_BIT = 0;
    localparam int SOFT_RST_BIT = 1;
    // device config bits
    localparam int ADDR_SEL_BIT = 0;
    localparam int REG_DIS_BIT = 1;
    // status bits
    localparam int INIT_BIT = 0;
    localparam int UART_RDY_BIT = 1;
    localparam int LINK_RDY_BIT = 2;
    localparam int AWAKE_BIT = 3;
    // device fault bits
    localparam int REF_FLT_BIT = 0;
    localparam int REF_GND_FLT_BIT = 1;
    localparam int FLT_W = 16;
    localparam int AM_W = 4;
    localparam int ADR_W = 5;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 200;
    localparam int NVM_WAIT_NS = 10000;
    localparam int NVM_WAIT_CYC = (NVM_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int TONE_CYC_DEF = 64;
    localparam int QUAL_PULSES_DEF = 4;
    localparam int TONE_GAP_CYC = 16;
    localparam int CNT_W = 16;
    // nonvolatile defaults
    localparam logic [1:0] NV_CFG_DEF = 2'h0;
    localparam logic [3:0] NV_AM_DEF = 4'h0;
    localparam logic [4:0] NV_ADDR_DEF = 5'h00;

    typedef enum {
        ST_SHUT, ST_NVM_WAIT, ST_LOAD, ST_ADDR, ST_TEMP, ST_CLEAR, ST_RUN
    } swr_state_t;
endpackage

// *** hw/swr_sequencer.sv ***
`timescale 1ns/1ps
module swr_sequencer #(
    parameter int TONE_CYC = swr_pkg::TONE_CYC_DEF,
    parameter int QUAL_PULSES = swr_pkg::QUAL_PULSES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic supplyGood,
    input wire logic wakePin,
    input wire logic southTonePulse,
    input wire logic analogSupplyFault,
    input wire logic [swr_pkg::ADR_W-1:0] gpioAddr,
    input wire logic tempDone,
    input wire logic sampleDone,
    input wire logic [swr_pkg::FLT_W-1:0] uvResult,
    input wire logic [swr_pkg::FLT_W-1:0] ovResult,
    input wire logic [swr_pkg::FLT_W-1:0] auxResult,
    input wire logic [1:0] refResult,
    input wire logic [swr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [swr_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [swr_pkg::DATA_W-1:0] regRdata,
    output logic northTone,
    output logic southTxEn,
    output logic uartEnable,
    output logic linkEnable,
    output logic tempSampleReq,
    output logic sampleReq,
    output logic analogFaultEn,
    output logic regulatorOn,
    output logic awake
);
    import swr_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        swr_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] toneCnt;
        logic tone;
        logic toneDone;
        logic [7:0] pulseCnt;
        logic [7:0] gapCnt;
        logic [2:0] wakeSync;
        logic wakeLvl;
        logic [2:0] toneSync;
        logic toneLvl;
        logic [2:0] supSync;
        logic [2:0] vmSync;
        logic vmLvl;
        logic [1:0] cfg;
        logic [AM_W-1:0] amPer;
        logic [ADR_W-1:0] addr;
        logic init;
        logic uartOn;
        logic linkOn;
        logic fltEn;
        logic resetFlt;
        logic regOn;
        logic tempReq;
        logic smpReq;
        logic [FLT_W-1:0] uv;
        logic [FLT_W-1:0] ov;
        logic [FLT_W-1:0] aux;
        logic [1:0] refF;
        logic [DATA_W-1:0] rdata;
    } swr_regs_t;

    swr_regs_t s_reg;
    swr_regs_t s_next;
    logic wakeHigh;
    logic toneHigh;
    logic supOk;
    logic vmFault;
    logic toneRise;
    logic qualTone;
    logic wr;
    logic runOpen;
    logic restart;

    always_comb begin
        // three-stage sync: change counts when stages two and three agree; supply ok only while both stages are high
        wakeHigh = (s_reg.wakeSync[1] == s_reg.wakeSync[2]) ? s_reg.wakeSync[2] : s_reg.wakeLvl;
        toneHigh = (s_reg.toneSync[1] == s_reg.toneSync[2]) ? s_reg.toneSync[2] : s_reg.toneLvl;
        supOk = s_reg.supSync[1] & s_reg.supSync[2];
        vmFault = (s_reg.vmSync[1] == s_reg.vmSync[2]) ? s_reg.vmSync[2] : s_reg.vmLvl;
        toneRise = toneHigh & ~s_reg.toneLvl;
        runOpen = s_reg.gapCnt != 8'(TONE_GAP_CYC);
        qualTone = toneRise && runOpen && (s_reg.pulseCnt == 8'(QUAL_PULSES - 1));
        wr = regWrite;
        // power-down with the wake pin still high cycles straight back up
        restart = (s_reg.st == ST_SHUT && supOk && (wakeHigh || toneHigh))
            || (s_reg.st != ST_SHUT && qualTone)
            || (s_reg.st != ST_SHUT && wr && regAddr == DEVICE_CONTROL_REG_OFS && regWdata[SOFT_RST_BIT])
            || (s_reg.st != ST_SHUT && wr && regAddr == DEVICE_CONTROL_REG_OFS && regWdata[PWR_DOWN_BIT] && wakeHigh);
        s_next = s_reg;
        s_next.wakeSync = {s_reg.wakeSync[1:0], wakePin};
        s_next.toneSync = {s_reg.toneSync[1:0], southTonePulse};
        s_next.supSync = {s_reg.supSync[1:0], supplyGood};
        s_next.vmSync = {s_reg.vmSync[1:0], analogSupplyFault};
        s_next.wakeLvl = wakeHigh;
        s_next.toneLvl = toneHigh;
        s_next.vmLvl = vmFault;
        s_next.tempReq = 1'b0;
        s_next.smpReq = 1'b0;
        s_next.rdata = '0;

        // ****************************************
        // received tone qualification
        // ****************************************
        // pulse run resets when the tone gap grows, so stray spikes never add up
        if (toneRise) begin
            s_next.gapCnt = 8'h00;
            s_next.pulseCnt = qualTone ? 8'h00 : (runOpen ? s_reg.pulseCnt + 8'h01 : 8'h01);
        end else if (runOpen) begin
            s_next.gapCnt = s_reg.gapCnt + 8'h01;
        end

        // north tone timer
        if (s_reg.tone) begin
            if (s_reg.toneCnt == CNT_W'(TONE_CYC - 1)) begin
                s_next.tone = 1'b0;
                s_next.toneDone = 1'b1;
            end else begin
                s_next.toneCnt = s_reg.toneCnt + 1'b1;
            end
        end

        // ****************************************
        // sequencer
        // ****************************************
        unique case (s_reg.st)
            ST_SHUT: begin
                s_next.pulseCnt = '0;
                if (supOk && (wakeHigh || toneHigh)) begin
                    s_next.st = ST_NVM_WAIT;
                end
            end
            ST_NVM_WAIT: begin
                if (s_reg.cnt == CNT_W'(NVM_WAIT_CYC - 1)) begin
                    s_next.cnt = '0;
                    s_next.st = ST_LOAD;
                end else begin
                    s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
            ST_LOAD: begin
                s_next.cfg = NV_CFG_DEF;
                s_next.amPer = NV_AM_DEF;
                s_next.addr = NV_ADDR_DEF;
                s_next.st = ST_ADDR;
            end
            ST_ADDR: begin
                if (!s_reg.cfg[ADDR_SEL_BIT]) begin
                    s_next.addr = gpioAddr;
                end
                s_next.tempReq = 1'b1;
                s_next.st = ST_TEMP;
            end
            ST_TEMP: begin
                if (tempDone) begin
                    s_next.st = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                s_next.uv = '0;
                s_next.ov = '0;
                s_next.aux = '0;
                s_next.refF = '0;
                s_next.uartOn = 1'b1;
                s_next.st = ST_RUN;
            end
            ST_RUN: begin
            end
        endcase

        // analog fault init runs beside the main walk
        // only after uart opens, so the reloaded auto period decides the first sample
        if (s_reg.st == ST_RUN && s_reg.init && (!vmFault)) begin
            s_next.init = 1'b0;
            s_next.fltEn = 1'b1;
            s_next.smpReq = (s_reg.amPer != '0);
        end
        if (s_reg.toneDone && s_reg.st != ST_SHUT) begin
            s_next.linkOn = 1'b1;
        end
        if (s_reg.regOn && !s_reg.resetFlt && s_reg.cfg[REG_DIS_BIT] && s_reg.st == ST_RUN) begin
            s_next.regOn = 1'b0;
        end

        // ****************************************
        // fault capture on sample
        // ****************************************
        if (sampleDone && s_reg.fltEn) begin
            s_next.uv = uvResult;
            s_next.ov = ovResult;
            s_next.aux = auxResult;
            s_next.refF = refResult;
        end

        // ****************************************
        // register port
        // ****************************************
        if (wr) begin
            unique case (regAddr)
                DEVICE_CONTROL_REG_OFS: ;
                DEV_CFG_OFS: s_next.cfg = regWdata[1:0];
                AUTO_MON_OFS: s_next.amPer = regWdata[AM_W-1:0];
                STATUS_OFS: begin
                    if (regWdata[INIT_BIT] && s_reg.init && s_reg.st == ST_RUN) begin
                        s_next.init = 1'b0;
                        s_next.fltEn = 1'b1;
                        s_next.smpReq = (s_reg.amPer != '0);
                    end
                end
                SYS_FAULT_OFS: begin
                    if (regWdata[0]) begin
                        s_next.resetFlt = 1'b0;
                    end
                end
                SAMPLE_CMD_OFS: s_next.smpReq = regWdata[0] & s_reg.fltEn;
                default: ;
            endcase
        end
        if (regRead) begin
            unique case (regAddr)
                DEV_CFG_OFS: s_next.rdata = DATA_W'(s_reg.cfg);
                AUTO_MON_OFS: s_next.rdata = DATA_W'(s_reg.amPer);
                STATUS_OFS: s_next.rdata = DATA_W'({s_reg.st != ST_SHUT, s_reg.linkOn, s_reg.uartOn, s_reg.init});
                SYS_FAULT_OFS: s_next.rdata = DATA_W'(s_reg.resetFlt);
                UV_FAULT_OFS: s_next.rdata = DATA_W'(s_reg.uv);
                OV_FAULT_OFS: s_next.rdata = DATA_W'(s_reg.ov);
                AUX_FAULT_OFS: s_next.rdata = DATA_W'(s_reg.aux);
                DEV_FAULT_OFS: s_next.rdata = DATA_W'(s_reg.refF);
                ADDR_OFS: s_next.rdata = DATA_W'(s_reg.addr);
                default: s_next.rdata = '0;
            endcase
        end

        // ****************************************
        // restart and shutdown
        // ****************************************
        // any restart path funnels through one reset of the walk
        if (restart) begin
            s_next.st = ST_NVM_WAIT;
            s_next.cnt = '0;
            s_next.tone = 1'b1;
            s_next.toneCnt = '0;
            s_next.toneDone = 1'b0;
            s_next.pulseCnt = '0;
            s_next.init = 1'b1;
            s_next.uartOn = 1'b0;
            s_next.linkOn = 1'b0;
            s_next.fltEn = 1'b0;
            s_next.resetFlt = 1'b1;
            s_next.regOn = 1'b1;
            s_next.uv = '0;
            s_next.ov = '0;
            s_next.aux = '0;
            s_next.refF = '0;
        end else if (s_reg.st != ST_SHUT && wr && regAddr == DEVICE_CONTROL_REG_OFS
                     && regWdata[PWR_DOWN_BIT] && !wakeHigh) begin
            s_next.st = ST_SHUT;
            s_next.tone = 1'b0;
            s_next.uartOn = 1'b0;
            s_next.linkOn = 1'b0;
            s_next.fltEn = 1'b0;
            s_next.regOn = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.st <= ST_SHUT;
        end else begin
            s_reg <= s_next;
        end
    end

    assign regRdata = s_reg.rdata;
    assign northTone = s_reg.tone;
    assign southTxEn = s_reg.linkOn;
    assign uartEnable = s_reg.uartOn;
    assign linkEnable = s_reg.linkOn;
    assign tempSampleReq = s_reg.tempReq;
    assign sampleReq = s_reg.smpReq;
    assign analogFaultEn = s_reg.fltEn;
    assign regulatorOn = s_reg.regOn;
    assign awake = s_reg.st != ST_SHUT;

    // ****************************************
    // check helpers
    // ****************************************
    // wait length counted apart from the sequencer's own counter
    logic [CNT_W-1:0] nvmAge_reg;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nvmAge_reg <= '0;
        end else if (s_reg.st == ST_NVM_WAIT && !restart) begin
            nvmAge_reg <= nvmAge_reg + 1'b1;
        end else begin
            nvmAge_reg <= '0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence nvmDone_s;
        s_reg.st == ST_NVM_WAIT ##1 s_reg.st == ST_LOAD;
    endsequence

    wake_tone_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(awake) |-> northTone) else $error("no tone on wake");
    tone_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(linkEnable) |-> $past(s_reg.toneDone)) else $error("link before tone end");
    nvm_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == ST_NVM_WAIT |-> nvmAge_reg < CNT_W'(NVM_WAIT_CYC)) else $error("nvm wait too long");
    nvm_end_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == ST_NVM_WAIT && nvmAge_reg == CNT_W'(NVM_WAIT_CYC - 1) && !restart |=> s_reg.st == ST_LOAD)
        else $error("nvm wait end missed");
    load_step_a: assert property (@(posedge ref_clk) disable iff (rst)
        nvmDone_s |=> s_reg.st == ST_ADDR) else $error("load skipped");
    pd_block_a: assert property (@(posedge ref_clk) disable iff (rst)
        awake && regWrite && regAddr == DEVICE_CONTROL_REG_OFS && wakeHigh |=> awake) else $error("shutdown with wake high");
    shut_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        !awake |-> !southTxEn) else $error("south tx in shutdown");
    uart_order_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(uartEnable) |-> $past(s_reg.st) == ST_CLEAR) else $error("uart early");
    fault_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_reg.st == ST_NVM_WAIT) |-> s_reg.uv == '0 && s_reg.refF == '0) else $error("faults not cleared");
    auto_mon_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(analogFaultEn) && s_reg.amPer != '0 |-> sampleReq) else $error("no first sample");
    reg_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == ST_RUN && regulatorOn && !s_reg.resetFlt && s_reg.cfg[REG_DIS_BIT] |=> !regulatorOn)
        else $error("regulator stays on");
    iso_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == ST_RUN && toneRise && !runOpen && !regWrite |=> s_reg.st == ST_RUN)
        else $error("isolated pulse restarted");
    fault_init_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(analogFaultEn) |-> $past(s_reg.st) == ST_RUN) else $error("fault init too early");
endmodule

// *** test/swr_far_model.sv ***
`timescale 1ns/1ps
// ****************************************
// analog die stand-in
// ****************************************
module swr_far_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic [15:0] pattern,
    input wire logic tempSampleReq,
    input wire logic sampleReq,
    output logic tempDone,
    output logic sampleDone,
    output logic [15:0] uvResult,
    output logic [15:0] ovResult,
    output logic [15:0] auxResult,
    output logic [1:0] refResult
);
    logic [7:0] tmpCnt;
    logic [7:0] smpCnt;
    logic [7:0] dly;
    assign dly = slow ? 8'h14 : 8'h02;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tmpCnt <= 8'h00;
            smpCnt <= 8'h00;
        end else begin
            tmpCnt <= tempSampleReq ? dly : (tmpCnt != 8'h00 ? tmpCnt - 8'h01 : 8'h00);
            smpCnt <= sampleReq ? dly : (smpCnt != 8'h00 ? smpCnt - 8'h01 : 8'h00);
        end
    end
    assign tempDone = tmpCnt == 8'h01;
    assign sampleDone = smpCnt == 8'h01;
    // results only valid in the done cycle; inverted (aux unswapped) otherwise so stale capture shows
    assign uvResult = sampleDone ? pattern : ~pattern;
    assign ovResult = sampleDone ? ~pattern : pattern;
    assign auxResult = sampleDone ? {pattern[7:0], pattern[15:8]} : pattern;
    assign refResult = sampleDone ? pattern[1:0] : ~pattern[1:0];
endmodule

// *** test/swr_sequencer_tb.sv ***
`timescale 1ns/1ps
module swr_sequencer_tb;
    import swr_pkg::*;
    localparam int QP = 3;
    typedef struct {string nm; logic [31:0] v;} swr_note_t;
    logic ref_clk = 1'b0, rst = 1'b1, supplyGood = 1'b0, wakePin = 1'b0, southTonePulse = 1'b0;
    logic analogSupplyFault = 1'b1, tempDone, sampleDone, regWrite = 1'b0, regRead = 1'b0;
    logic [ADR_W-1:0] gpioAddr = 5'h00;
    logic [FLT_W-1:0] uvResult, ovResult, auxResult;
    logic [1:0] refResult;
    logic [ADDR_W-1:0] regAddr = 4'h0;
    logic [DATA_W-1:0] regWdata = 32'h0, regRdata, seed;
    logic northTone, southTxEn, uartEnable, linkEnable, tempSampleReq, sampleReq;
    logic analogFaultEn, regulatorOn, awake, slow = 1'b0, rdPend = 1'b0;
    logic [15:0] pattern = 16'h0000;
    swr_note_t expQ[$];
    int miscompares = 0, cmp_count = 0, tempCnt = 0, smpCnt = 0, early = 0;
    always #2.5 ref_clk = ~ref_clk;
    swr_sequencer #(.TONE_CYC(40), .QUAL_PULSES(QP)) uut (.ref_clk, .rst, .supplyGood, .wakePin,
        .southTonePulse, .analogSupplyFault, .gpioAddr, .tempDone, .sampleDone, .uvResult, .ovResult,
        .auxResult, .refResult, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .northTone,
        .southTxEn, .uartEnable, .linkEnable, .tempSampleReq, .sampleReq, .analogFaultEn,
        .regulatorOn, .awake);
    swr_far_model far (.ref_clk, .rst, .slow, .pattern, .tempSampleReq, .sampleReq, .tempDone,
        .sampleDone, .uvResult, .ovResult, .auxResult, .refResult);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic sel(input int i);
        case (i)
            0: sel = awake;
            1: sel = uartEnable;
            2: sel = analogFaultEn;
            3: sel = sampleReq;
            4: sel = linkEnable;
            default: sel = northTone;
        endcase
    endfunction
    // bounded wait; also counts init-time sample requests and early link opening
    task automatic wait_hi(input int i, input logic v, input int lim, input string nm);
        int n;
        n = 0;
        while (sel(i) !== v && n < lim) begin
            @(posedge ref_clk);
            n++;
            if (tempSampleReq === 1'b1) tempCnt++;
            if (sampleReq === 1'b1) smpCnt++;
            if (linkEnable === 1'b1 && northTone === 1'b1) early++;
        end
        if (n >= lim) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", nm, v, ~v);
            summarize();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        expQ.push_back('{nm, e});
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic tone(input int n);
        repeat (n) begin
            southTonePulse <= 1'b1;
            repeat (4) @(posedge ref_clk);
            southTonePulse <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    task automatic init_done();
        tempCnt = 0;
        smpCnt = 0;
        early = 0;
        wait_hi(1, 1'b1, 3000, "uartEnable");
        wait_hi(4, 1'b1, 60, "linkEnable");
        chk("temp requests", 1, tempCnt);
        chk("init sample requests", 0, smpCnt);
        chk("link before tone end", 0, early);
    endtask
    // ****************************************
    // read data monitor
    // ****************************************
    always @(posedge ref_clk) begin
        if (rdPend) begin
            if (expQ.size() == 0) chk("read queue", 1, 0);
            else chk(expQ[0].nm, expQ[0].v, regRdata);
            if (expQ.size() != 0) void'(expQ.pop_front());
        end
        rdPend = regRead;
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        seed = 32'h4DB6;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("south tx after reset", 0, southTxEn);
        seed = lfsr(seed);
        pattern <= seed[15:0];
        gpioAddr <= seed[20:16];
        supplyGood <= 1'b1;
        wakePin <= 1'b1;
        wait_hi(0, 1'b1, 20, "awake");
        @(posedge ref_clk);
        chk("north tone", 1, northTone);
        wakePin <= 1'b0;
        init_done();
        rd(STATUS_OFS, 32'hF, "status in init");
        rd(ADDR_OFS, {27'h0, gpioAddr}, "address");
        rd(UV_FAULT_OFS, 32'h0, "uv before sample");
        rd(DEV_FAULT_OFS, 32'h0, "ref before sample");
        rd(DEV_CFG_OFS, 32'h0, "config default");
        wr(AUTO_MON_OFS, 32'h3);
        analogSupplyFault <= 1'b0;
        wait_hi(2, 1'b1, 20, "analogFaultEn");
        wait_hi(3, 1'b1, 4, "auto sample");
        repeat (10) @(posedge ref_clk);
        rd(UV_FAULT_OFS, {16'h0, pattern}, "uv sampled");
        rd(OV_FAULT_OFS, {16'h0, ~pattern}, "ov sampled");
        rd(STATUS_OFS, 32'hE, "status after init");
        $display("wake pin test done");
        wr(DEV_CFG_OFS, 32'h1 << REG_DIS_BIT);
        @(posedge ref_clk);
        chk("regulator held", 1, regulatorOn);
        rd(SYS_FAULT_OFS, 32'h1, "reset fault");
        wr(SYS_FAULT_OFS, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk("regulator off", 0, regulatorOn);
        $display("regulator test done");
        pattern <= ~pattern;
        wr(SAMPLE_CMD_OFS, 32'h0);
        rd(UV_FAULT_OFS, {16'h0, ~pattern}, "uv not refreshed");
        wr(SAMPLE_CMD_OFS, 32'h1);
        repeat (10) @(posedge ref_clk);
        rd(UV_FAULT_OFS, {16'h0, pattern}, "uv on command");
        slow <= 1'b1;
        wr(DEVICE_CONTROL_REG_OFS, 32'h1 << SOFT_RST_BIT);
        wait_hi(1, 1'b0, 20, "uart closed");
        wait_hi(5, 1'b1, 20, "soft reset tone");
        init_done();
        rd(AUTO_MON_OFS, 32'h0, "auto period reload");
        rd(UV_FAULT_OFS, 32'h0, "uv after soft reset");
        $display("soft reset test done");
        tone(1);
        repeat (30) @(posedge ref_clk);
        chk("single pulse ignored", 1, uartEnable);
        tone(QP - 1);
        repeat (30) @(posedge ref_clk);
        chk("short run ignored", 1, uartEnable);
        tone(QP);
        wait_hi(1, 1'b0, 40, "tone reset");
        wait_hi(5, 1'b1, 20, "forwarded tone");
        init_done();
        $display("tone reset test done");
        wakePin <= 1'b1;
        repeat (5) @(posedge ref_clk);
        wr(DEVICE_CONTROL_REG_OFS, 32'h1 << PWR_DOWN_BIT);
        wait_hi(1, 1'b0, 20, "reawake restart");
        chk("reawake tone", 1, northTone);
        repeat (20) @(posedge ref_clk);
        chk("reawake with pin high", 1, awake);
        wakePin <= 1'b0;
        wait_hi(1, 1'b1, 3000, "uart after reawake");
        wr(DEVICE_CONTROL_REG_OFS, 32'h1 << PWR_DOWN_BIT);
        wait_hi(0, 1'b0, 20, "shutdown");
        repeat (20) @(posedge ref_clk);
        chk("south tx in shutdown", 0, southTxEn);
        tone(1);
        wait_hi(0, 1'b1, 20, "tone wake");
        chk("tone forwarded", 1, northTone);
        init_done();
        rd(ADDR_OFS, {27'h0, gpioAddr}, "address after tone wake");
        $display("shutdown test done");
        summarize();
    end
endmodule
